/* shared/sadd_pkg.sv */
// Constants, types and carriers shared by the serial adder sequencer
package sadd_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int SADD_WORD_W = 12;
    localparam int SADD_CNT_W  = 4;

    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] SADD_OFF_CTRL = 8'h00;
    localparam logic [7:0] SADD_OFF_ACC  = 8'h04;
    localparam logic [7:0] SADD_OFF_WORD = 8'h08;
    localparam logic [7:0] SADD_OFF_STAT = 8'h0C;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int SADD_CTRL_RUN      = 0;
    localparam int SADD_CTRL_OP_LSB   = 1;
    localparam int SADD_CTRL_FTEN     = 4;
    localparam int SADD_CTRL_FELEVEN  = 5;
    localparam int SADD_CTRL_SCNT_LSB = 8;
    localparam int SADD_STAT_CARRY    = 0;
    localparam int SADD_STAT_OVF      = 1;
    localparam int SADD_STAT_BUSY     = 2;
    localparam int SADD_STAT_SKIP     = 3;
    localparam int SADD_STAT_PH_LSB   = 4;
    localparam int SADD_STAT_CNT_LSB  = 8;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [31:0] SADD_CTRL_RST  = 32'h0000_0000;
    localparam logic [11:0] SADD_WORD_RST  = 12'h000;
    localparam logic [3:0]  SADD_CNT_RST   = 4'h0;
    localparam logic [3:0]  SADD_END_ADD   = 4'hB;
    localparam logic [3:0]  SADD_END_INC   = 4'hD;
    localparam logic [3:0]  SADD_END_SHIFT = 4'h0;
    localparam logic [1:0]  SADD_TAIL_ADD  = 2'h2;

    // ------------------------------------------------------------
    // Enumerations
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE     = 3'b000,
        OP_ADD      = 3'b001,
        OP_AND_ACC  = 3'b010,
        OP_INC_SKIP = 3'b011,
        OP_LOG_RSH  = 3'b100,
        OP_ARI_RSH  = 3'b101,
        OP_ROT_RSH  = 3'b110
    } sadd_op_t;

    typedef enum logic [3:0] {
        PH_IDLE   = 4'b0000,
        PH_FETCH1 = 4'b0001,
        PH_FETCH2 = 4'b0010,
        PH_FETCH3 = 4'b0011,
        PH_FETCH4 = 4'b0100,
        PH_FETCH5 = 4'b0101,
        PH_FETCH6 = 4'b0110,
        PH_EXEC1  = 4'b0111,
        PH_EXEC2  = 4'b1000,
        PH_EXEC3  = 4'b1001,
        PH_EXEC4  = 4'b1010,
        PH_EXEC5  = 4'b1011,
        PH_EXEC6  = 4'b1100
    } sadd_phase_t;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic        addr_reset;
        logic        cycle_start;
        logic        read_select;
        logic [11:0] wdata;
    } sadd_mem_t;

    typedef struct packed {
        sadd_phase_t phase;
        logic        counter_step;
        logic        acc_shift;
        logic        word_shift;
        logic        arith_timing;
        logic        end_of_count;
        logic        mem_cycle_cond;
        logic        pc_advance;
        logic        fetch_start;
    } sadd_timing_t;

endpackage

/* logic/sadd_core.sv */
// Bit-serial adder sequencer: add, and-to-accumulator, increment-skip
`timescale 1ns/1ps
// Overview of operation
// - Add/and: step counter on entering execute three, no data shift.
// - Step counter entering execute four; hold there while count not ended.
// - Function ten low, eleven high: timing on, end flag false, shifts on.
// - First pulse in execute four shifts both registers, third counter step.
// - Each clock shifts and steps; end flag at count 11, after shift nine.
// - Next clock enters fetch one, skipping execute five; two shifts more.
// - Add: sum is full-adder sum of accumulator bit, word bit, carry.
// - Add: carry sets on both ones, holds on any one, clears on none.
// - Carry still set after add sets overflow in next fetch four.
// - And: shift in one only when both low bits are one; no carry.
// - Increment-skip: read word, increment serially, write back, skip on zero.
// - Execute one: reset address logic and word, set carry, start read.
// - Increment-skip: step in three, load memory word, step entering four.
// - Increment-skip: only word shift pulses; they clock carry too.
// - Carry and one: shift zero; first zero: shift one, clear carry.
// - Increment-skip ends count at 13 after 11 shifts; no fetch in four.
// - After shift 11: clear read select, cycle condition, skip if zero.
// - Next clock: execute five, shift 12, clear/write cycle in five, six.
// - Increment-skip execute six raises fetch start for next clock.
// - Right shifts load ones complement count; rotate routes low bit to high.
// - Carry cleared in fetch five of every instruction.
module sadd_core
    import sadd_pkg::*;
#(
    parameter int WORD_W = SADD_WORD_W
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // APB slave
    input  wire logic         psel,
    input  wire logic         penable,
    input  wire logic         pwrite,
    input  wire logic [7:0]   paddr,
    input  wire logic [31:0]  pwdata,
    output logic [31:0]       prdata,
    output logic              pready,
    output logic              pslverr,
    // Core memory
    input  wire logic [11:0]  mem_rdata,
    output sadd_mem_t         mem_out,
    // Timing and control strobes
    output sadd_timing_t      timing_out
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    sadd_phase_t       phase;
    sadd_phase_t       next_phase;
    sadd_op_t          op;
    logic [31:0]       ctrl;
    logic [WORD_W-1:0] acc;
    logic [WORD_W-1:0] word;
    logic [3:0]        cnt;
    logic [1:0]        tail;
    logic              carry_flop;
    logic              overflow_flop;
    logic              skip_seen;
    logic              read_select;
    logic              cycle_start;
    sadd_op_t          ctrl_op;
    logic              function_bit_ten;
    logic              function_bit_eleven;
    logic              op_shift;
    logic              op_addlike;
    logic              arith_shift_timing;
    logic              end_of_count_flag;
    logic [3:0]        count_end;
    logic              in_hold;
    logic              do_shift;
    logic              accumulator_shift_pulse;
    logic              word_shift_pulse;
    logic              counter_step_pulse;
    logic              adder_sum_out;
    logic              next_carry;
    logic              inc_done;
    logic              program_counter_advance;
    logic              fetch_start_condition;
    logic              address_logic_reset;
    logic              apb_wr;
    logic              apb_rd;
    logic              busy;

    assign ctrl_op             = sadd_op_t'(ctrl[SADD_CTRL_OP_LSB +: 3]);
    assign function_bit_ten    = ctrl[SADD_CTRL_FTEN];
    assign function_bit_eleven = ctrl[SADD_CTRL_FELEVEN];
    assign busy                = (phase != PH_IDLE);
    assign apb_wr              = psel & penable & pready & pwrite;
    assign apb_rd              = psel & ~penable;

    // ------------------------------------------------------------
    // Decode and shift control
    // ------------------------------------------------------------
    always_comb begin
        op_shift   = (op == OP_LOG_RSH) | (op == OP_ARI_RSH) |
                     (op == OP_ROT_RSH);
        op_addlike = (op == OP_ADD) | (op == OP_AND_ACC);
        in_hold    = (phase == PH_EXEC4) & (op != OP_NONE);
        // Shift timing from the function bits; shifts use their own path
        arith_shift_timing = in_hold &
            ((~function_bit_ten & function_bit_eleven) | op_shift);
        if (op == OP_INC_SKIP) begin
            count_end = SADD_END_INC;
        end else if (op_shift) begin
            count_end = SADD_END_SHIFT;
        end else begin
            count_end = SADD_END_ADD;
        end
        // Flag is forced false while timing runs and count not reached
        end_of_count_flag = ~arith_shift_timing |
                            (cnt == count_end);
        do_shift = arith_shift_timing | (tail != 2'h0);
        accumulator_shift_pulse = do_shift &
                                  (op_addlike | op_shift);
        word_shift_pulse = do_shift &
                           (op_addlike | (op == OP_INC_SKIP));
        counter_step_pulse = ((phase == PH_EXEC2) & (op != OP_NONE)) |
                             ((phase == PH_EXEC3) & (op != OP_NONE)) |
                             arith_shift_timing;
        inc_done = in_hold & (op == OP_INC_SKIP) &
                   arith_shift_timing & (cnt == SADD_END_INC);
        program_counter_advance = inc_done & word[0] &
                                  carry_flop;
        fetch_start_condition = (phase == PH_EXEC6) |
                                ((phase == PH_EXEC3) & (op == OP_NONE));
        address_logic_reset = (phase == PH_EXEC1);
    end

    // ------------------------------------------------------------
    // Serial adder
    // ------------------------------------------------------------
    always_comb begin
        adder_sum_out = 1'b0;
        next_carry    = carry_flop;
        case (op)
            OP_ADD: begin
                adder_sum_out = acc[0] ^ word[0] ^ carry_flop;
                next_carry = carry_flop ? (acc[0] | word[0])
                                        : (acc[0] & word[0]);
            end
            OP_AND_ACC: begin
                adder_sum_out = acc[0] & word[0];
                next_carry    = 1'b0;
            end
            OP_INC_SKIP: begin
                adder_sum_out = word[0] ^ carry_flop;
                next_carry    = word[0] & carry_flop;
            end
            OP_ARI_RSH: begin
                adder_sum_out = acc[WORD_W-1];
            end
            OP_ROT_RSH: begin
                adder_sum_out = acc[0];
            end
            default: begin
                adder_sum_out = 1'b0;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Timer phase sequencing
    // ------------------------------------------------------------
    always_comb begin
        next_phase = phase;
        case (phase)
            PH_IDLE: begin
                if (ctrl[SADD_CTRL_RUN]) begin
                    next_phase = PH_FETCH1;
                end
            end
            PH_FETCH1: next_phase = PH_FETCH2;
            PH_FETCH2: next_phase = PH_FETCH3;
            PH_FETCH3: next_phase = PH_FETCH4;
            PH_FETCH4: next_phase = PH_FETCH5;
            PH_FETCH5: next_phase = PH_FETCH6;
            PH_FETCH6: begin
                next_phase = ctrl[SADD_CTRL_RUN] ? PH_EXEC1 : PH_IDLE;
            end
            PH_EXEC1: next_phase = PH_EXEC2;
            PH_EXEC2: next_phase = PH_EXEC3;
            PH_EXEC3: begin
                next_phase = (op == OP_NONE) ? PH_FETCH1 : PH_EXEC4;
            end
            PH_EXEC4: begin
                // Held here until the count ends; increment-skip never
                // starts a fetch from this phase
                if (end_of_count_flag) begin
                    next_phase = (op == OP_INC_SKIP) ? PH_EXEC5
                                                     : PH_FETCH1;
                end
            end
            PH_EXEC5: next_phase = PH_EXEC6;
            PH_EXEC6: next_phase = PH_FETCH1;
            default:  next_phase = PH_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= PH_IDLE;
        end else begin
            phase <= next_phase;
        end
    end

    // Instruction latched at the end of fetch; held through the next
    // fetch so the overflow check sees the previous instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op <= OP_NONE;
        end else if (phase == PH_FETCH6) begin
            op <= ctrl_op;
        end
    end

    // ------------------------------------------------------------
    // Shift counter and trailing shifts
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= SADD_CNT_RST;
        end else if (phase == PH_EXEC1) begin
            cnt <= op_shift ? ~ctrl[SADD_CTRL_SCNT_LSB +: 4]
                            : SADD_CNT_RST;
        end else if (counter_step_pulse) begin
            cnt <= cnt + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tail <= 2'h0;
        end else if (in_hold & op_addlike & end_of_count_flag &
                     arith_shift_timing) begin
            tail <= SADD_TAIL_ADD;
        end else if (tail != 2'h0) begin
            tail <= tail - 2'h1;
        end
    end

    // ------------------------------------------------------------
    // Accumulator and word registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            acc <= SADD_WORD_RST;
        end else if (accumulator_shift_pulse) begin
            acc <= {adder_sum_out, acc[WORD_W-1:1]};
        end else if (apb_wr & ~busy & (paddr == SADD_OFF_ACC)) begin
            acc <= pwdata[WORD_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            word <= SADD_WORD_RST;
        end else if (phase == PH_EXEC1 && op != OP_NONE) begin
            word <= SADD_WORD_RST;
        end else if (phase == PH_EXEC3 && op != OP_NONE) begin
            word <= mem_rdata[WORD_W-1:0];
        end else if (word_shift_pulse) begin
            word <= {adder_sum_out, word[WORD_W-1:1]};
        end
    end

    // ------------------------------------------------------------
    // Carry, overflow and skip flags
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carry_flop <= 1'b0;
        end else if (phase == PH_EXEC1 && op == OP_INC_SKIP) begin
            carry_flop <= 1'b1;
        end else if (phase == PH_FETCH5) begin
            carry_flop <= 1'b0;
        end else if ((op == OP_INC_SKIP) ? word_shift_pulse
                                         : accumulator_shift_pulse) begin
            carry_flop <= next_carry;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            overflow_flop <= 1'b0;
        end else if (phase == PH_FETCH4 && op == OP_ADD && carry_flop) begin
            overflow_flop <= 1'b1;
        end else if (accumulator_shift_pulse & acc[0] &
                     ((op == OP_LOG_RSH) | (op == OP_ARI_RSH))) begin
            overflow_flop <= 1'b1;
        end else if (apb_wr && paddr == SADD_OFF_STAT &&
                     pwdata[SADD_STAT_OVF]) begin
            overflow_flop <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            skip_seen <= 1'b0;
        end else if (program_counter_advance) begin
            skip_seen <= 1'b1;
        end else if (apb_wr && paddr == SADD_OFF_STAT &&
                     pwdata[SADD_STAT_SKIP]) begin
            skip_seen <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Memory cycle control
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_select <= 1'b1;
        end else if (inc_done) begin
            read_select <= 1'b0;
        end else if (phase == PH_FETCH1) begin
            read_select <= 1'b1;
        end
    end

    // Level that spans the memory cycle: read in execute two and three,
    // write in execute five and six
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cycle_start <= 1'b0;
        end else if (phase == PH_EXEC1 &&
                     (op_addlike | (op == OP_INC_SKIP))) begin
            cycle_start <= 1'b1;
        end else if (inc_done) begin
            cycle_start <= 1'b1;
        end else if (phase == PH_EXEC3 || phase == PH_EXEC6) begin
            cycle_start <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mem_out <= '0;
        end else begin
            mem_out.addr_reset  <= address_logic_reset;
            mem_out.cycle_start <= cycle_start;
            mem_out.read_select <= read_select;
            mem_out.wdata       <= word;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timing_out <= '0;
        end else begin
            timing_out.phase          <= phase;
            timing_out.counter_step   <= counter_step_pulse;
            timing_out.acc_shift      <= accumulator_shift_pulse;
            timing_out.word_shift     <= word_shift_pulse;
            timing_out.arith_timing   <= arith_shift_timing;
            timing_out.end_of_count   <= end_of_count_flag;
            timing_out.mem_cycle_cond <= inc_done;
            timing_out.pc_advance     <= program_counter_advance;
            timing_out.fetch_start    <= fetch_start_condition;
        end
    end

    // ------------------------------------------------------------
    // APB register access
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= SADD_CTRL_RST;
        end else if (apb_wr && paddr == SADD_OFF_CTRL) begin
            ctrl <= pwdata;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= apb_rd;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
            if (apb_rd) begin
                if (paddr == SADD_OFF_CTRL) begin
                    prdata <= ctrl;
                end else if (paddr == SADD_OFF_ACC) begin
                    prdata <= {20'h00000, acc};
                end else if (paddr == SADD_OFF_WORD) begin
                    prdata <= {20'h00000, word};
                end else if (paddr == SADD_OFF_STAT) begin
                    prdata[SADD_STAT_CARRY] <= carry_flop;
                    prdata[SADD_STAT_OVF]   <= overflow_flop;
                    prdata[SADD_STAT_BUSY]  <= busy;
                    prdata[SADD_STAT_SKIP]  <= skip_seen;
                    prdata[SADD_STAT_PH_LSB +: 4] <= phase;
                    prdata[SADD_STAT_CNT_LSB +: 4] <= cnt;
                end else begin
                    pslverr <= 1'b1;
                end
            end
        end
    end

endmodule // sadd_core

/* verification/sadd_assertions.sv */
// Port-level timing checks for the serial adder sequencer
`timescale 1ns/1ps
module sadd_assertions
    import sadd_pkg::*;
(
    // Clock and reset
    input wire logic         pclk,
    input wire logic         presetn,
    // Observed ports
    input wire logic         psel,
    input wire logic         penable,
    input wire logic         pready,
    input wire sadd_mem_t    mem_out,
    input wire sadd_timing_t timing_out
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sadd_phase_t ph;
    assign ph = timing_out.phase;
    sequence s_exec6_exit;
        ph == PH_EXEC6 ##1 ph == PH_FETCH1;
    endsequence
    a_apb_ready_pulse: assert property (psel && !penable |=> pready ##1 !pready)
        else $error("pready not one cycle after setup");
    a_exec3_no_shift: assert property (ph == PH_EXEC3 |->
        !timing_out.acc_shift && !timing_out.word_shift)
        else $error("shift pulse in execute three");
    a_exec3_step: assert property ($rose(ph == PH_EXEC3) |->
        ##[0:1] timing_out.counter_step)
        else $error("no counter step on entering execute three");
    a_exec4_hold: assert property (ph == PH_EXEC4 &&
        !timing_out.end_of_count |=> ph == PH_EXEC4)
        else $error("timer left execute four before count end");
    a_skip_with_cond: assert property (timing_out.pc_advance |->
        timing_out.mem_cycle_cond)
        else $error("skip pulse without memory cycle condition");
    a_cond_to_exec5: assert property (timing_out.mem_cycle_cond |=>
        ph == PH_EXEC5)
        else $error("no execute five after memory cycle condition");
    a_exec6_write: assert property (ph == PH_EXEC6 |->
        mem_out.cycle_start && !mem_out.read_select)
        else $error("no write cycle in execute six");
    a_exec6_fetch: assert property (ph == PH_EXEC6 |->
        timing_out.fetch_start ##0 s_exec6_exit)
        else $error("execute six not followed by fetch one");
    a_exec1_addr_rst: assert property ($rose(ph == PH_EXEC1) |->
        ##[0:1] mem_out.addr_reset)
        else $error("no address reset in execute one");
    a_timing_shifts: assert property (timing_out.arith_timing |->
        ph == PH_EXEC4 && (timing_out.acc_shift || timing_out.word_shift))
        else $error("shift timing outside execute four shifting");
endmodule // sadd_assertions
bind sadd_core sadd_assertions u_sadd_chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pready(pready), .mem_out(mem_out),
    .timing_out(timing_out));

/* verification/sadd_mem_model.sv */
// One-word core memory model facing the sequencer
`timescale 1ns/1ps
module sadd_mem_model
    import sadd_pkg::*;
(
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // Bench preload
    input  wire logic        load_en,
    input  wire logic [11:0] load_word,
    // Sequencer side
    input  wire sadd_mem_t   mem_out,
    output logic [11:0]      mem_rdata,
    output logic [11:0]      word
);
    logic [11:0] last_out;
    // Outside a read the lines toggle, so stale data never looks valid
    assign mem_rdata = (mem_out.cycle_start && mem_out.read_select) ?
                       word : ~last_out;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_out <= 12'h000;
        end else begin
            last_out <= mem_rdata;
        end
    end
    always_ff @(posedge pclk) begin
        if (load_en) begin
            word <= load_word;
        end else if (mem_out.cycle_start && !mem_out.read_select) begin
            word <= mem_out.wdata;
        end
    end
endmodule // sadd_mem_model

/* verification/testbench.sv */
// Self-checking bench for the serial adder sequencer
`timescale 1ns/1ps
module testbench;
    import sadd_pkg::*;
    logic         pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic         load_en;
    logic [7:0]   paddr;
    logic [11:0]  mem_rdata, mem_word, load_word;
    logic [31:0]  pwdata, prdata;
    sadd_mem_t    mem_out;
    sadd_timing_t timing_out;
    int           n_fail, n_compared, n_acc, n_word, cyc;
    sadd_core dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_rdata(mem_rdata), .mem_out(mem_out), .timing_out(timing_out));
    sadd_mem_model mem (.pclk(pclk), .presetn(presetn), .load_en(load_en),
        .load_word(load_word), .mem_out(mem_out), .mem_rdata(mem_rdata),
        .word(mem_word));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        n_acc <= n_acc + timing_out.acc_shift;
        n_word <= n_word + timing_out.word_shift;
        if (cyc == 20000) begin
            n_fail++;
            end_of_test();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("Mismatches %0d, comparisons %0d", n_fail, n_compared);
        if (n_fail == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r, output logic e);
        int t;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        t = 0;
        do begin
            @(posedge pclk);
            t++;
        end while (pready !== 1'b1 && t < 20);
        r = prdata;
        e = pslverr;
        if (t == 20) n_fail++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic run_op(input logic [31:0] ctrl);
        logic [31:0] s;
        logic        e;
        apb(1'b1, SADD_OFF_CTRL, ctrl | 32'h1, s, e);
        do apb(1'b0, SADD_OFF_STAT, 32'h0, s, e); while (s[7:4] < 4'h7);
        apb(1'b1, SADD_OFF_CTRL, ctrl, s, e);
        do apb(1'b0, SADD_OFF_STAT, 32'h0, s, e); while (s[2] === 1'b1);
    endtask
    initial begin
        logic [31:0] r;
        logic        e;
        int          a, w, n, x, ovf, na, nw;
        sadd_op_t    op;
        logic [3:0]  fb;
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {load_en, load_word} = '0;
        void'($urandom(20));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, SADD_OFF_CTRL, 32'h0, r, e);
        check(r, SADD_CTRL_RST);
        apb(1'b0, SADD_OFF_STAT, 32'h0, r, e);
        check(r, 32'h0);
        apb(1'b0, 8'h10, 32'h0, r, e);
        check(32'(e), 32'h1);
        for (int i = 0; i < 14; i++) begin
            op = sadd_op_t'(1 + i % 6);
            a = $urandom & 32'hFFF;
            w = (i == 2) ? 32'hFFF : $urandom & 32'hFFF;
            n = 1 + $urandom % 11;
            load_en <= 1'b1;
            load_word <= w[11:0];
            @(posedge pclk);
            load_en <= 1'b0;
            apb(1'b1, SADD_OFF_ACC, 32'(a), r, e);
            apb(1'b1, SADD_OFF_STAT, 32'hA, r, e);
            na = n_acc;
            nw = n_word;
            fb = (i == 13) ? 4'h3 : 4'h2;
            run_op({20'h0, 4'(n), fb, op, 1'b0});
            x = op == OP_ADD ? a + w : op == OP_AND_ACC ? a & w :
                op == OP_LOG_RSH ? a >> n : op == OP_ARI_RSH ?
                (a << 20) >>> (20 + n) : op == OP_ROT_RSH ?
                (a | a << 12) >> n : a;
            ovf = op == OP_ADD ? (a + w) >> 12 : op inside {OP_LOG_RSH,
                OP_ARI_RSH} ? int'((a & ((1 << n) - 1)) != 0) : 0;
            if (fb != 4'h2) x = a;
            n = (fb == 4'h2) ? 12 : 0;
            apb(1'b0, SADD_OFF_ACC, 32'h0, r, e);
            check(r, 32'(x & 32'hFFF));
            apb(1'b0, SADD_OFF_STAT, 32'h0, r, e);
            check(32'(r[1]), 32'(ovf));
            check(32'(r[0]), 32'h0);
            check(32'(r[3]), 32'(op == OP_INC_SKIP && w == 32'hFFF));
            if (op == OP_INC_SKIP) begin
                check(32'(mem_word), 32'((w + 1) & 32'hFFF));
                check(32'(n_word - nw), 32'd12);
                check(32'(n_acc - na), 32'd0);
            end
            if (op == OP_ADD || op == OP_AND_ACC) begin
                check(32'(n_acc - na), 32'(n));
            end
        end
        end_of_test();
    end
endmodule // testbench
